// ==== core/capture_input.sv ====
`timescale 1ns/10ps
`default_nettype none
module capture_input (
	input wire logic mclk,
	input wire logic rst,
	input wire logic capture_pin,
	input wire logic analog_comp_out,
	input wire logic analog_comp_sel,
	input wire logic capture_filter_en,
	input wire logic capture_edge_sel,
	input wire logic capture_enable,
	output logic capture_event
);
	logic source;
	logic [timer_pkg::FILTER_SAMPLES-1:0] history;
	logic filtered;
	logic level;
	logic level_prev;

	assign source = analog_comp_sel ? analog_comp_out : capture_pin;

	always_ff @(posedge mclk) begin
		if (rst) begin
			history <= timer_pkg::FILTER_ZEROS;
			filtered <= 1'b0;
			level_prev <= 1'b0;
		end else begin
			history <= {history[timer_pkg::FILTER_SAMPLES-2:0], source};
			// output changes only after four equal samples
			if (history == timer_pkg::FILTER_ONES) begin
				filtered <= 1'b1;
			end else if (history == timer_pkg::FILTER_ZEROS) begin
				filtered <= 1'b0;
			end
			level_prev <= level;
		end
	end

	assign level = capture_filter_en ? filtered : history[0];
	// zero picks the falling edge, one the rising edge
	assign capture_event = capture_enable & (capture_edge_sel ? (level & ~level_prev) : (~level & level_prev));
endmodule
`default_nettype wire

// ==== core/clock_select.sv ====
`timescale 1ns/10ps
`default_nettype none
module clock_select (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [2:0] clock_source_sel,
	input wire logic external_count_pin,
	output logic timer_tick
);
	logic [timer_pkg::PRESCALE_W-1:0] prescale;
	logic ext_prev;
	logic ext_rise;
	logic ext_fall;

	always_ff @(posedge mclk) begin
		if (rst) begin
			prescale <= timer_pkg::PRESCALE_RESET;
			ext_prev <= 1'b0;
		end else begin
			prescale <= prescale + 10'h001;
			// the pin is watched whatever its port direction
			ext_prev <= external_count_pin;
		end
	end

	assign ext_rise = external_count_pin & ~ext_prev;
	assign ext_fall = ~external_count_pin & ext_prev;

	always_comb begin
		unique case (clock_source_sel)
			timer_pkg::CS_STOP: timer_tick = 1'b0;
			timer_pkg::CS_DIV1: timer_tick = 1'b1;
			timer_pkg::CS_DIV8: timer_tick = (prescale & timer_pkg::MASK_DIV8) == timer_pkg::MASK_DIV8;
			timer_pkg::CS_DIV64: timer_tick = (prescale & timer_pkg::MASK_DIV64) == timer_pkg::MASK_DIV64;
			timer_pkg::CS_DIV256: timer_tick = (prescale & timer_pkg::MASK_DIV256) == timer_pkg::MASK_DIV256;
			timer_pkg::CS_DIV1024: timer_tick = prescale == timer_pkg::MASK_DIV1024;
			timer_pkg::CS_EXT_FALL: timer_tick = ext_fall;
			timer_pkg::CS_EXT_RISE: timer_tick = ext_rise;
		endcase
	end
endmodule
`default_nettype wire

// ==== core/timer16.sv ====
// Summary of operation
// - two mode bits in control A and two in control B form the 4-bit mode.
// - mode 0 counts up to 0xFFFF, immediate compare, overflow at max.
// - modes 4 and 12 clear on match, top from compare A or capture.
// - modes 1-3,10,11 phase correct; buffers load at top, overflow at bottom.
// - modes 8,9 phase and frequency correct; load and overflow at bottom.
// - filter passes a capture level only after four equal samples.
// - edge select zero means falling edge, one means rising edge.
// - capture copies the counter into the capture register and sets the flag.
// - capture pin is ignored while the capture register is the top.
// - clock select 0 stops; 1 to 5 divide the clock by 1,8,64,256,1024.
// - clock select 6 and 7 count falling and rising external pin edges.
// - the external count pin clocks the counter even when driven as output.
// - sixteen-bit registers pass through one shared high-byte latch.
// - a counter write blocks compare matches on the next timer clock.
// - both compare values are compared continuously, giving flag and waveform.
// - capture source is the capture pin or the analog comparator output.
// - with capture register as top, the capture flag sets at top.
// - flags clear on vector acknowledge or on writing one to them.
`timescale 1ns/10ps
`default_nettype none
module timer16 (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [timer_pkg::ADDR_W-1:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_wr,
	input wire logic io_rd,
	output logic [7:0] io_rdata,
	input wire logic capture_pin,
	input wire logic analog_comp_out,
	input wire logic analog_comp_sel,
	input wire logic external_count_pin,
	input wire logic [3:0] flag_ack,
	output logic overflow_flag,
	output logic compare_flag_b,
	output logic compare_flag_a,
	output logic capture_flag,
	output logic [1:0] compare_wave_out
);
	logic [1:0] waveform_mode_low;
	logic [7:0] timer_control_b;
	logic [15:0] count;
	logic [15:0] next_count;
	logic [15:0] capture_value;
	logic [15:0] cmp_buf [2];
	logic [15:0] cmp_act [2];
	logic [15:0] cmp_use [2];
	logic [7:0] temp_high;
	logic [3:0] flags;
	logic [3:0] flag_set;
	logic [3:0] flag_clr;
	logic [1:0] wave;
	logic [1:0] match;
	logic block_match;
	timer_pkg::dir_t dir;
	timer_pkg::dir_t next_dir;
	timer_pkg::family_t family;
	logic [15:0] top;
	logic top_is_capt;
	logic [3:0] waveform_mode_sel;
	logic [1:0] waveform_mode_high;
	logic [2:0] clock_source_sel;
	logic capture_filter_en;
	logic capture_edge_sel;
	logic timer_tick;
	logic capture_event;
	logic dual_slope;
	logic immediate;
	logic at_top;
	logic at_bottom;
	logic at_max;
	logic load_now;
	logic count_wr;
	logic capt_wr;
	logic [1:0] cmp_wr;
	logic high_addr;
	logic [15:0] word_sel;
	logic [7:0] read_byte;
	logic [15:0] write_word;

	// control fields
	assign waveform_mode_high = timer_control_b[timer_pkg::CTRL_B_MODE_HI +: 2];
	assign waveform_mode_sel = {waveform_mode_high, waveform_mode_low};
	assign clock_source_sel = timer_control_b[timer_pkg::CTRL_B_CLKSEL +: 3];
	assign capture_filter_en = timer_control_b[timer_pkg::CTRL_B_FILTER];
	assign capture_edge_sel = timer_control_b[timer_pkg::CTRL_B_EDGE];

	// mode decode: counting family and source of top
	always_comb begin
		unique case (waveform_mode_sel)
			4'h0: begin
				family = timer_pkg::FAM_NORMAL;
				top = timer_pkg::TOP_MAX;
			end
			4'h1: begin
				family = timer_pkg::FAM_PC;
				top = timer_pkg::TOP_8BIT;
			end
			4'h2: begin
				family = timer_pkg::FAM_PC;
				top = timer_pkg::TOP_9BIT;
			end
			4'h3: begin
				family = timer_pkg::FAM_PC;
				top = timer_pkg::TOP_10BIT;
			end
			4'h4: begin
				family = timer_pkg::FAM_CTC;
				top = cmp_use[0];
			end
			4'h5: begin
				family = timer_pkg::FAM_FAST;
				top = timer_pkg::TOP_8BIT;
			end
			4'h6: begin
				family = timer_pkg::FAM_FAST;
				top = timer_pkg::TOP_9BIT;
			end
			4'h7: begin
				family = timer_pkg::FAM_FAST;
				top = timer_pkg::TOP_10BIT;
			end
			4'h8: begin
				family = timer_pkg::FAM_PFC;
				top = capture_value;
			end
			4'h9: begin
				family = timer_pkg::FAM_PFC;
				top = cmp_use[0];
			end
			4'ha: begin
				family = timer_pkg::FAM_PC;
				top = capture_value;
			end
			4'hb: begin
				family = timer_pkg::FAM_PC;
				top = cmp_use[0];
			end
			4'hc: begin
				family = timer_pkg::FAM_CTC;
				top = capture_value;
			end
			4'hd: begin
				family = timer_pkg::FAM_NORMAL;
				top = timer_pkg::TOP_MAX;
			end
			4'he: begin
				family = timer_pkg::FAM_FAST;
				top = capture_value;
			end
			4'hf: begin
				family = timer_pkg::FAM_FAST;
				top = cmp_use[0];
			end
		endcase
	end

	assign top_is_capt = (waveform_mode_sel == 4'h8) | (waveform_mode_sel == 4'ha) |
		(waveform_mode_sel == 4'hc) | (waveform_mode_sel == 4'he);
	assign dual_slope = (family == timer_pkg::FAM_PC) | (family == timer_pkg::FAM_PFC);
	assign immediate = (family == timer_pkg::FAM_NORMAL) | (family == timer_pkg::FAM_CTC);

	// counter events, all qualified by the timer clock
	assign at_top = timer_tick & (count == top);
	assign at_bottom = timer_tick & dual_slope & (dir == timer_pkg::DIR_DOWN) & (count == timer_pkg::BOTTOM);
	assign at_max = timer_tick & (count == timer_pkg::TOP_MAX);
	// fast pwm loads on the wrap into bottom, phase correct at top
	assign load_now = ((family == timer_pkg::FAM_PC) & at_top) |
		((family == timer_pkg::FAM_PFC) & at_bottom) |
		((family == timer_pkg::FAM_FAST) & at_top);

	clock_select u_clock_select (
		.mclk(mclk),
		.rst(rst),
		.clock_source_sel(clock_source_sel),
		.external_count_pin(external_count_pin),
		.timer_tick(timer_tick)
	);

	capture_input u_capture_input (
		.mclk(mclk),
		.rst(rst),
		.capture_pin(capture_pin),
		.analog_comp_out(analog_comp_out),
		.analog_comp_sel(analog_comp_sel),
		.capture_filter_en(capture_filter_en),
		.capture_edge_sel(capture_edge_sel),
		.capture_enable(~top_is_capt),
		.capture_event(capture_event)
	);

	// cpu access: high byte goes through the shared latch
	assign high_addr = (io_addr == timer_pkg::ADDR_COUNT_H) | (io_addr == timer_pkg::ADDR_CMP_A_H) |
		(io_addr == timer_pkg::ADDR_CMP_B_H) | (io_addr == timer_pkg::ADDR_CAPT_H);
	assign write_word = {temp_high, io_wdata};
	assign count_wr = io_wr & (io_addr == timer_pkg::ADDR_COUNT_L);
	assign cmp_wr[0] = io_wr & (io_addr == timer_pkg::ADDR_CMP_A_L);
	assign cmp_wr[1] = io_wr & (io_addr == timer_pkg::ADDR_CMP_B_L);
	assign capt_wr = io_wr & (io_addr == timer_pkg::ADDR_CAPT_L);

	always_comb begin
		unique case (io_addr)
			timer_pkg::ADDR_COUNT_L: word_sel = count;
			timer_pkg::ADDR_CMP_A_L: word_sel = cmp_buf[0];
			timer_pkg::ADDR_CMP_B_L: word_sel = cmp_buf[1];
			timer_pkg::ADDR_CAPT_L: word_sel = capture_value;
			default: word_sel = timer_pkg::WORD_RESET;
		endcase
	end

	always_comb begin
		unique case (io_addr)
			timer_pkg::ADDR_CTRL_A: read_byte = {6'h00, waveform_mode_low};
			timer_pkg::ADDR_CTRL_B: read_byte = timer_control_b;
			timer_pkg::ADDR_FLAGS: read_byte = {2'h0, flags, 2'h0};
			default: read_byte = high_addr ? temp_high : word_sel[7:0];
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			io_rdata <= timer_pkg::BYTE_RESET;
			temp_high <= timer_pkg::BYTE_RESET;
		end else begin
			if (io_rd) begin
				io_rdata <= read_byte;
			end
			// low-byte read freezes the high byte for the following read
			if (io_wr & high_addr) begin
				temp_high <= io_wdata;
			end else if (io_rd & ~high_addr & (io_addr >= timer_pkg::ADDR_COUNT_L) &
				(io_addr <= timer_pkg::ADDR_CAPT_L)) begin
				temp_high <= word_sel[15:8];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			waveform_mode_low <= timer_pkg::CTRL_A_RESET;
			timer_control_b <= timer_pkg::CTRL_B_RESET;
		end else begin
			if (io_wr & (io_addr == timer_pkg::ADDR_CTRL_A)) begin
				waveform_mode_low <= io_wdata[1:0];
			end
			if (io_wr & (io_addr == timer_pkg::ADDR_CTRL_B)) begin
				timer_control_b <= io_wdata & 8'hdf;
			end
		end
	end

	// counter sequence
	always_comb begin
		next_count = count;
		next_dir = dir;
		if (count_wr) begin
			next_count = write_word;
		end else if (timer_tick & dual_slope) begin
			if (dir == timer_pkg::DIR_UP) begin
				if (count >= top) begin
					next_dir = timer_pkg::DIR_DOWN;
					next_count = count - 16'h0001;
				end else begin
					next_count = count + 16'h0001;
				end
			end else if (count == timer_pkg::BOTTOM) begin
				next_dir = timer_pkg::DIR_UP;
				next_count = count + 16'h0001;
			end else begin
				next_count = count - 16'h0001;
			end
		end else if (timer_tick) begin
			next_count = (count == top) ? timer_pkg::BOTTOM : count + 16'h0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			count <= timer_pkg::WORD_RESET;
			dir <= timer_pkg::DIR_UP;
			block_match <= 1'b0;
		end else begin
			count <= next_count;
			dir <= next_dir;
			if (count_wr) begin
				block_match <= 1'b1;
			end else if (timer_tick) begin
				block_match <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			capture_value <= timer_pkg::WORD_RESET;
		end else if (capt_wr) begin
			capture_value <= write_word;
		end else if (capture_event) begin
			capture_value <= count;
		end
	end

	// compare units: buffer, active value, match and waveform
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_cmp
			assign cmp_use[ch] = immediate ? cmp_buf[ch] : cmp_act[ch];
			assign match[ch] = timer_tick & ~block_match & (count == cmp_use[ch]);

			always_ff @(posedge mclk) begin
				if (rst) begin
					cmp_buf[ch] <= timer_pkg::WORD_RESET;
					cmp_act[ch] <= timer_pkg::WORD_RESET;
					wave[ch] <= 1'b0;
				end else begin
					if (cmp_wr[ch]) begin
						cmp_buf[ch] <= write_word;
					end
					if (load_now | immediate) begin
						cmp_act[ch] <= cmp_buf[ch];
					end
					if ((family == timer_pkg::FAM_FAST) & at_top) begin
						wave[ch] <= 1'b1;
					end else if (match[ch] & dual_slope) begin
						wave[ch] <= (dir == timer_pkg::DIR_DOWN);
					end else if (match[ch] & (family == timer_pkg::FAM_FAST)) begin
						wave[ch] <= 1'b0;
					end else if (match[ch]) begin
						wave[ch] <= ~wave[ch];
					end
				end
			end
		end
	endgenerate

	assign compare_wave_out = wave;

	// flags: a set in the same cycle as a clear wins
	assign flag_set[timer_pkg::FLAG_OVF] = (immediate & at_max) |
		((family == timer_pkg::FAM_FAST) & at_top) |
		at_bottom;
	assign flag_set[timer_pkg::FLAG_CMP_B] = match[1];
	assign flag_set[timer_pkg::FLAG_CMP_A] = match[0];
	assign flag_set[timer_pkg::FLAG_CAPT] = capture_event | (top_is_capt & at_top);
	assign flag_clr = flag_ack | ((io_wr & (io_addr == timer_pkg::ADDR_FLAGS)) ?
		io_wdata[timer_pkg::FLAG_REG_LSB +: 4] : 4'h0);

	always_ff @(posedge mclk) begin
		if (rst) begin
			flags <= timer_pkg::FLAGS_RESET;
		end else begin
			flags <= flag_set | (flags & ~flag_clr);
		end
	end

	assign overflow_flag = flags[timer_pkg::FLAG_OVF];
	assign compare_flag_b = flags[timer_pkg::FLAG_CMP_B];
	assign compare_flag_a = flags[timer_pkg::FLAG_CMP_A];
	assign capture_flag = flags[timer_pkg::FLAG_CAPT];
endmodule
`default_nettype wire

// ==== core/timer_pkg.sv ====
package timer_pkg;

	// byte addresses of the timer's i/o locations
	localparam int unsigned ADDR_W = 4;
	localparam logic [3:0] ADDR_CTRL_A = 4'h0;
	localparam logic [3:0] ADDR_CTRL_B = 4'h1;
	localparam logic [3:0] ADDR_COUNT_L = 4'h2;
	localparam logic [3:0] ADDR_COUNT_H = 4'h3;
	localparam logic [3:0] ADDR_CMP_A_L = 4'h4;
	localparam logic [3:0] ADDR_CMP_A_H = 4'h5;
	localparam logic [3:0] ADDR_CMP_B_L = 4'h6;
	localparam logic [3:0] ADDR_CMP_B_H = 4'h7;
	localparam logic [3:0] ADDR_CAPT_L = 4'h8;
	localparam logic [3:0] ADDR_CAPT_H = 4'h9;
	localparam logic [3:0] ADDR_FLAGS = 4'ha;

	// field positions
	localparam int unsigned CTRL_B_FILTER = 7;
	localparam int unsigned CTRL_B_EDGE = 6;
	localparam int unsigned CTRL_B_RSVD = 5;
	localparam int unsigned CTRL_B_MODE_HI = 3;
	localparam int unsigned CTRL_B_CLKSEL = 0;
	localparam int unsigned FLAG_REG_LSB = 2;
	localparam int unsigned FLAG_OVF = 0;
	localparam int unsigned FLAG_CMP_B = 1;
	localparam int unsigned FLAG_CMP_A = 2;
	localparam int unsigned FLAG_CAPT = 3;

	// values after reset
	localparam logic [1:0] CTRL_A_RESET = 2'h0;
	localparam logic [7:0] CTRL_B_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [3:0] FLAGS_RESET = 4'h0;

	// top values
	localparam logic [15:0] TOP_MAX = 16'hffff;
	localparam logic [15:0] TOP_8BIT = 16'h00ff;
	localparam logic [15:0] TOP_9BIT = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;
	localparam logic [15:0] BOTTOM = 16'h0000;

	// clock select codes
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam int unsigned PRESCALE_W = 10;
	localparam logic [9:0] PRESCALE_RESET = 10'h000;
	localparam logic [9:0] MASK_DIV8 = 10'h007;
	localparam logic [9:0] MASK_DIV64 = 10'h03f;
	localparam logic [9:0] MASK_DIV256 = 10'h0ff;
	localparam logic [9:0] MASK_DIV1024 = 10'h3ff;

	// capture noise filter length in samples
	localparam int unsigned FILTER_SAMPLES = 4;
	localparam logic [3:0] FILTER_ONES = 4'hf;
	localparam logic [3:0] FILTER_ZEROS = 4'h0;

	typedef enum logic [4:0] {
		FAM_NORMAL = 5'b00001,
		FAM_CTC = 5'b00010,
		FAM_PC = 5'b00100,
		FAM_PFC = 5'b01000,
		FAM_FAST = 5'b10000
	} family_t;

	typedef enum logic [1:0] {
		DIR_UP = 2'b01,
		DIR_DOWN = 2'b10
	} dir_t;

endpackage

// ==== test/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] io_addr = 4'h0;
	logic [7:0] io_wdata = 8'h00;
	logic io_wr = 1'b0;
	logic io_rd = 1'b0;
	logic capture_pin = 1'b0;
	logic analog_comp_out = 1'b0;
	logic analog_comp_sel = 1'b0;
	logic external_count_pin = 1'b0;
	logic [3:0] flag_ack = 4'h0;
	logic [7:0] io_rdata;
	logic overflow_flag;
	logic compare_flag_b;
	logic compare_flag_a;
	logic capture_flag;
	logic [1:0] compare_wave_out;
	int error_cnt = 0;
	int total_checks = 0;
	int seed = 32'h2b00;
	int span;
	int divs[6] = '{0, 1, 8, 64, 256, 1024};
	int modes[12] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 11, 14, 15};
	int tops[12] = '{255, 511, 1023, 64, 255, 511, 1023, 64, 64, 64, 64, 64};
	logic [15:0] m16[4];
	logic [15:0] v;
	logic [15:0] w;
	logic [7:0] b;

	always #20 mclk = ~mclk;

	timer16 i_dut (
		.mclk(mclk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
		.io_rdata(io_rdata), .capture_pin(capture_pin), .analog_comp_out(analog_comp_out),
		.analog_comp_sel(analog_comp_sel), .external_count_pin(external_count_pin), .flag_ack(flag_ack),
		.overflow_flag(overflow_flag), .compare_flag_b(compare_flag_b), .compare_flag_a(compare_flag_a),
		.capture_flag(capture_flag), .compare_wave_out(compare_wave_out)
	);

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic summarize();
		if (error_cnt == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		tick(1);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		tick(1);
		io_wr = 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		tick(1);
		io_addr = a;
		io_rd = 1'b1;
		tick(1);
		io_rd = 1'b0;
		d = io_rdata;
	endtask
	// high byte first so the low byte commits the pair
	task automatic wr16(input logic [3:0] a, input logic [15:0] d);
		wr(a + 4'h1, d[15:8]);
		wr(a, d[7:0]);
	endtask
	task automatic rd16(input logic [3:0] a, output logic [15:0] d);
		rd(a, d[7:0]);
		rd(a + 4'h1, d[15:8]);
	endtask

	initial begin
		tick(40000);
		error_cnt++;
		summarize();
	end

	initial begin
		tick(2);
		rst = 1'b0;
		for (int a = 0; a < 16; a++) begin
			rd(4'(a), b);
			chk("reset read", 16'(b), 16'h0000);
		end
		for (int i = 0; i < 5; i++) begin
			b = 8'($random(seed));
			wr(4'h0, b & 8'hfe);
			wr(4'h1, b & 8'hdf);
			rd(4'h0, v[7:0]);
			chk("control a", 16'(v[7:0]), 16'(b & 8'h02));
			rd(4'h1, v[7:0]);
			chk("control b", 16'(v[7:0]), 16'(b & 8'hdf));
			wr(4'hb + 4'(i), b);
			rd(4'hb + 4'(i), v[7:0]);
			chk("unmapped", 16'(v[7:0]), 16'h0000);
		end
		wr(4'h1, 8'h00);
		wr(4'h0, 8'h00);
		for (int k = 0; k < 4; k++) begin
			m16[k] = 16'($random(seed));
			wr16(4'(2 + 2 * k), m16[k]);
		end
		// a low-byte read between the halves steals the shared latch
		wr(4'h5, 8'haa);
		rd(4'ha, b);
		rd(4'h9, b);
		chk("latch", 16'(b), 16'h00aa);
		rd(4'h2, b);
		wr(4'h4, 8'h55);
		m16[1] = {m16[0][15:8], 8'h55};
		for (int k = 0; k < 4; k++) begin
			rd16(4'(2 + 2 * k), v);
			chk("word", v, m16[k]);
		end
		for (int cs = 0; cs < 6; cs++) begin
			span = (cs < 2) ? 64 : 2 * divs[cs];
			wr(4'h1, 8'(cs));
			rd16(4'h2, v);
			tick(span - 4);
			rd16(4'h2, w);
			chk("count step", w - v, 16'((cs == 0) ? 0 : span / divs[cs]));
		end
		for (int k = 0; k < 2; k++) begin
			wr(4'h1, 8'h00);
			wr(4'ha, 8'h3c);
			wr16(4'h2, 16'hfff0);
			wr(4'h1, 8'h01);
			tick(40);
			wr(4'h1, 8'h00);
			chk("overflow", 16'(overflow_flag), 16'h0001);
			if (k == 0)
				wr(4'ha, 8'h04);
			else begin
				flag_ack = 4'hf;
				tick(1);
				flag_ack = 4'h0;
			end
			chk("overflow clear", 16'(overflow_flag), 16'h0000);
		end
		wr16(4'h4, 16'h0100);
		wr16(4'h6, 16'h00f8);
		wr16(4'h2, 16'h00f0);
		wr(4'ha, 8'h3c);
		w = 16'(compare_wave_out);
		wr(4'h1, 8'h01);
		tick(30);
		chk("match a", 16'(compare_flag_a), 16'h0001);
		chk("wave toggle", 16'(compare_wave_out), w ^ 16'h0003);
		chk("match b", 16'(compare_flag_b), 16'h0001);
		wr(4'ha, 8'h3c);
		wr16(4'h2, 16'h0100);
		tick(20);
		wr(4'h1, 8'h00);
		chk("blocked match", 16'(compare_flag_a), 16'h0000);
		for (int k = 0; k < 4; k++) begin
			v = 16'($random(seed));
			wr16(4'h2, v);
			wr(4'h1, {k[1], k[0], 6'h00});
			capture_pin = ~k[0];
			tick(12);
			wr(4'ha, 8'h20);
			capture_pin = k[0];
			tick(2);
			capture_pin = ~k[0];
			tick(12);
			chk("glitch", 16'(capture_flag), 16'(!k[1]));
			if (!k[1])
				m16[3] = v;
			rd16(4'h8, w);
			chk("capture", w, m16[3]);
			wr(4'ha, 8'h20);
			capture_pin = k[0];
			tick(12);
			chk("edge", 16'(capture_flag), 16'h0001);
			m16[3] = v;
			wr(4'ha, 8'h20);
			capture_pin = ~k[0];
			tick(12);
			chk("wrong edge", 16'(capture_flag), 16'h0000);
		end
		wr(4'h1, 8'h40);
		analog_comp_sel = 1'b1;
		tick(12);
		wr(4'ha, 8'h20);
		capture_pin = 1'b1;
		tick(12);
		chk("pin ignored", 16'(capture_flag), 16'h0000);
		analog_comp_out = 1'b1;
		tick(12);
		chk("comparator", 16'(capture_flag), 16'h0001);
		analog_comp_out = 1'b0;
		capture_pin = 1'b0;
		tick(12);
		analog_comp_sel = 1'b0;
		wr(4'h1, 8'h58);
		tick(12);
		wr(4'ha, 8'h20);
		capture_pin = 1'b1;
		tick(12);
		chk("capture at top", 16'(capture_flag), 16'h0000);
		rd16(4'h8, w);
		chk("capture kept", w, m16[3]);
		capture_pin = 1'b0;
		wr(4'h1, 8'h00);
		for (int cs = 6; cs < 8; cs++) begin
			wr(4'h1, 8'(cs));
			rd16(4'h2, v);
			for (int i = 0; i < 9; i++) begin
				external_count_pin = ~external_count_pin;
				tick(3);
			end
			tick(4);
			rd16(4'h2, w);
			chk("external count", w - v, 16'((cs == 7) ? 5 : 4));
			external_count_pin = 1'b0;
			tick(3);
		end
		wr16(4'h4, 16'h0040);
		wr16(4'h8, 16'h0040);
		for (int k = 0; k < 12; k++) begin
			wr(4'h1, 8'h00);
			wr(4'h0, 8'(modes[k] & 3));
			wr16(4'h2, 16'h0000);
			wr(4'ha, 8'h3c);
			wr(4'h1, 8'((modes[k] >> 2) << 3) | 8'h01);
			tick(2 * tops[k] + 20);
			wr(4'h1, 8'((modes[k] >> 2) << 3));
			chk("mode overflow", 16'(overflow_flag), 16'(modes[k] != 4));
			rd16(4'h2, v);
			chk("within top", 16'(v <= 16'(tops[k])), 16'h0001);
			chk("top capture", 16'(capture_flag), 16'(modes[k] == 8 || modes[k] == 14));
		end
		summarize();
	end
endmodule

bind timer16 timer16_assertions u_chk (
	.mclk(mclk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
	.io_rdata(io_rdata), .capture_pin(capture_pin), .analog_comp_out(analog_comp_out),
	.analog_comp_sel(analog_comp_sel), .external_count_pin(external_count_pin), .flag_ack(flag_ack),
	.overflow_flag(overflow_flag), .compare_flag_b(compare_flag_b), .compare_flag_a(compare_flag_a),
	.capture_flag(capture_flag), .compare_wave_out(compare_wave_out)
);
`default_nettype wire

// ==== test/timer16_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module timer16_assertions (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [timer_pkg::ADDR_W-1:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_rdata,
	input wire logic capture_pin,
	input wire logic analog_comp_out,
	input wire logic analog_comp_sel,
	input wire logic external_count_pin,
	input wire logic [3:0] flag_ack,
	input wire logic overflow_flag,
	input wire logic compare_flag_b,
	input wire logic compare_flag_a,
	input wire logic capture_flag,
	input wire logic [1:0] compare_wave_out
);
	logic [1:0] ctl_a;
	logic [7:0] ctl_b;
	logic [7:0] latch;
	logic latch_ok;
	logic [3:0] stop_cnt;
	// shadow of control and shared latch, as software last left them
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctl_a <= 2'h0;
			ctl_b <= 8'h00;
			latch <= 8'h00;
			latch_ok <= 1'b0;
			stop_cnt <= 4'h0;
		end else begin
			if (io_wr && io_addr == timer_pkg::ADDR_CTRL_A)
				ctl_a <= io_wdata[1:0];
			if (io_wr && io_addr == timer_pkg::ADDR_CTRL_B)
				ctl_b <= io_wdata & 8'hdf;
			if (io_wr && io_addr[0] && io_addr > 4'h2 && io_addr < 4'ha) begin
				latch <= io_wdata;
				latch_ok <= 1'b1;
			end else if (io_rd && !io_addr[0] && io_addr > 4'h1 && io_addr < 4'h9)
				latch_ok <= 1'b0;
			if (ctl_b[2:0] != timer_pkg::CS_STOP)
				stop_cnt <= 4'h0;
			else if (stop_cnt != 4'hf)
				stop_cnt <= stop_cnt + 4'h1;
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	property p_rdata_hold;
		!io_rd |=> $stable(io_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
	property p_ctrl_a;
		io_rd && io_addr == timer_pkg::ADDR_CTRL_A |=> io_rdata == {6'h00, $past(ctl_a)};
	endproperty
	a_ctrl_a: assert property (p_ctrl_a) else $error("control a readback wrong");
	property p_ctrl_b;
		io_rd && io_addr == timer_pkg::ADDR_CTRL_B |=> io_rdata == $past(ctl_b);
	endproperty
	a_ctrl_b: assert property (p_ctrl_b) else $error("control b readback wrong");
	property p_unmapped;
		io_rd && io_addr > timer_pkg::ADDR_FLAGS |=> io_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_latch;
		io_rd && io_addr[0] && io_addr > 4'h2 && io_addr < 4'ha && latch_ok |=> io_rdata == $past(latch);
	endproperty
	a_latch: assert property (p_latch) else $error("high byte read not from latch");
	property p_flags;
		io_rd && io_addr == timer_pkg::ADDR_FLAGS |=>
			io_rdata == {2'h0, $past(capture_flag), $past(compare_flag_a), $past(compare_flag_b), $past(overflow_flag), 2'h0};
	endproperty
	a_flags: assert property (p_flags) else $error("flag readback wrong");
	property p_ovf_sticky;
		overflow_flag && !flag_ack[0] && !(io_wr && io_addr == timer_pkg::ADDR_FLAGS && io_wdata[2]) |=> overflow_flag;
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag dropped");
	property p_stop_flags;
		stop_cnt > 4'h4 && !overflow_flag && !compare_flag_a |=> !overflow_flag && !compare_flag_a;
	endproperty
	a_stop_flags: assert property (p_stop_flags) else $error("flag set while stopped");
	property p_stop_wave;
		stop_cnt > 4'h4 |=> $stable(compare_wave_out);
	endproperty
	a_stop_wave: assert property (p_stop_wave) else $error("waveform moved while stopped");
	c_ovf: cover property ($rose(overflow_flag));
	c_cmp: cover property ($rose(compare_flag_a));
	c_capt: cover property ($rose(capture_flag));
endmodule
`default_nettype wire
